/* dcc_pkg.sv */
// package: register map, field positions and reset values of the comparator control block
package dcc_pkg;

  // register indices (printed offsets are not all multiples of four)
  localparam logic [19:0] DCC_IDX_FILTER_EDGE = 20'hf0341;
  localparam logic [19:0] DCC_IDX_OUTPUT_CTRL = 20'hf0342;
  localparam logic [19:0] DCC_IDX_REF_GEN_CTRL = 20'hf0343;
  localparam logic [19:0] DCC_IDX_REF_LEVEL_CH0 = 20'hf0344;
  localparam logic [19:0] DCC_IDX_REF_LEVEL_CH1 = 20'hf0345;
  localparam logic [19:0] DCC_IDX_INPUT_SEL_CH0 = 20'hf034a;
  // extra register for the comparator enables, not in the table
  localparam logic [19:0] DCC_IDX_COMP_ENABLE = 20'hf0340;

  // byte address is four times the index
  localparam logic [21:0] DCC_ADDR_FILTER_EDGE = {DCC_IDX_FILTER_EDGE, 2'b00};
  localparam logic [21:0] DCC_ADDR_OUTPUT_CTRL = {DCC_IDX_OUTPUT_CTRL, 2'b00};
  localparam logic [21:0] DCC_ADDR_REF_GEN_CTRL = {DCC_IDX_REF_GEN_CTRL, 2'b00};
  localparam logic [21:0] DCC_ADDR_REF_LEVEL_CH0 = {DCC_IDX_REF_LEVEL_CH0, 2'b00};
  localparam logic [21:0] DCC_ADDR_REF_LEVEL_CH1 = {DCC_IDX_REF_LEVEL_CH1, 2'b00};
  localparam logic [21:0] DCC_ADDR_INPUT_SEL_CH0 = {DCC_IDX_INPUT_SEL_CH0, 2'b00};
  localparam logic [21:0] DCC_ADDR_COMP_ENABLE = {DCC_IDX_COMP_ENABLE, 2'b00};

  // reset values
  localparam logic [7:0] DCC_RST_REG = 8'h00;

  // field positions in filter_edge_control (ch0 low nibble, ch1 high nibble)
  localparam int DCC_FE_FCK_LSB = 0;
  localparam int DCC_FE_EPO = 2;
  localparam int DCC_FE_EDG = 3;
  localparam int DCC_CH_NIBBLE = 4;
  // field positions in output_control
  localparam int DCC_OC_IE = 0;
  localparam int DCC_OC_OE = 1;
  localparam int DCC_OC_OP = 2;
  localparam int DCC_OC_TWMD = 7;
  // reference generator control
  localparam int DCC_RG_RAIL = 0;
  localparam int DCC_RG_EN = 1;
  // input select ch0
  localparam int DCC_IS_MINUS_LSB = 0;
  localparam int DCC_IS_PLUS = 7;
  // writable masks (reserved bits read zero)
  localparam logic [7:0] DCC_MASK_OUTPUT_CTRL = 8'hf7;
  localparam logic [7:0] DCC_MASK_REF_GEN_CTRL = 8'h33;
  localparam logic [7:0] DCC_MASK_INPUT_SEL_CH0 = 8'h83;
  localparam logic [7:0] DCC_MASK_COMP_ENABLE = 8'h11;

  // filter sampling dividers and match depth
  localparam int DCC_DIV_8 = 8;
  localparam int DCC_DIV_32 = 32;
  localparam logic [4:0] DCC_DIV8_LAST = 5'(DCC_DIV_8 - 1);
  localparam logic [4:0] DCC_DIV32_LAST = 5'(DCC_DIV_32 - 1);
  localparam int DCC_MATCH_DEPTH = 3;

  // filter clock selection codes
  typedef enum logic [1:0] {
    DCC_FCK_BYPASS = 2'b00,
    DCC_FCK_DIV1 = 2'b01,
    DCC_FCK_DIV8 = 2'b10,
    DCC_FCK_DIV32 = 2'b11
  } dcc_fck_t;

  // bus slave data phase state
  typedef enum logic [0:0] {
    DCC_BUS_IDLE = 1'b0,
    DCC_BUS_DATA = 1'b1
  } dcc_bus_t;

endpackage : dcc_pkg

/* dcc_top.sv */
// top: register file, filters, edge detect and pin shaping of the dual comparator control
// Function
// (RQ1) irq on selected edge when edge mode 0, both edges when 1
// (RQ2) single-edge: rising edge when polarity bit 0, falling when 1
// (RQ3) filter clock 00 bypass; 01 sysclk, 10 sysclk/8, 11 sysclk/32 sampling
// (RQ4) software unlinks event and clears flag before changing filter or edge bits; the testbench clears the flag after the change
// (RQ5) software waits four sampling periods after enabling the filter
// (RQ6) software sets pin enable only with comparator and reference running
// (RQ7) output control register resets to zero, all outputs disabled
// (RQ8) ch1 window mode: pin gated by timer window and enable together
// (RQ9) software clears edge mode, sets window mode, then enable separately
// (RQ10) output polarity bit 0 passes result, 1 inverts it
// (RQ11) pin enable 0 blocks result from pin, 1 passes it
// (RQ12) raising irq enable may set pending flag; software clears it
// (RQ13) software unlinks event before toggling pin enable, then clears flag
// (RQ14) reference enable runs generator; rail bit picks supply or ground source
// (RQ15) software changes rail select only with generator stopped
// (RQ16) 8-bit reference code n sets level supply/256 times n
// (RQ17) software rewrites reference code only with generator disabled
// (RQ18) reference code registers written as whole bytes only
// (RQ19) software changes ch0 input selection only with comparator 0 off
// (RQ20) software avoids reference pins as rails while shared as inputs
// (RQ21) comparator 0 shaped result feeds the pwm cutoff unit
// (RQ22) software disables comparators before changing speed mode bit
// (RQ23) filter takes level after three matching samples, at next sample
// (RQ24) window mode: ch1 irq passes while window high, held 0 when low
// (RQ25) ch0 minus select 00 internal, 01 fixed 1.45 V, 10 pin, 11 prohibited
// (RQ26) ch0 plus select 0 analog pin, 1 gain amplifier output
//
// Register access over AHB-Lite is this design's own decision.
module dcc_top
  import dcc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [1:0] COMPARE_RAW,
  input wire logic TIMER_WINDOW_SIGNAL,
  output logic [1:0] IRQ_REQUEST,
  output logic COMPARE_OUT_PIN0,
  output logic COMPARE_OUT_PIN1,
  output logic PWM_CUTOFF_SOURCE,
  output logic [1:0] COMPARATOR_ENABLE,
  output logic [1:0] REF_GENERATOR_ENABLE,
  output logic [1:0] REF_RAIL_SELECT,
  output logic [7:0] REF_LEVEL_CODE0,
  output logic [7:0] REF_LEVEL_CODE1,
  output logic PLUS_INPUT_SELECT,
  output logic [1:0] MINUS_INPUT_SELECT
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    dcc_bus_t bus_st;
    logic wr_pend;
    logic [21:0] addr;
    logic [31:0] rdata;
    logic [7:0] filter_edge;
    logic [7:0] output_ctrl;
    logic [7:0] ref_gen_ctrl;
    logic [7:0] ref_level0;
    logic [7:0] ref_level1;
    logic [7:0] input_sel0;
    logic [7:0] comp_enable;
    logic [1:0] raw_s1;
    logic [1:0] raw_s2;
    logic [4:0] prescale;
    logic [5:0] samples;
    logic [1:0] filt_out;
    logic [1:0] filt_prev;
    logic [1:0] ie_prev;
    logic [1:0] irq;
    logic pin0;
    logic pin1;
    logic pwm_cut;
    logic win_s1;
    logic win_s2;
  } dcc_state_t;

  dcc_state_t s_q;
  dcc_state_t s_d;

  // sampling strobe for one channel from its filter clock field
  function automatic logic samp_tick(input logic [1:0] fck, input logic [4:0] pre);
    logic t;
    t = 1'b0;
    case (dcc_fck_t'(fck))
      DCC_FCK_DIV1: t = 1'b1;
      DCC_FCK_DIV8: t = (pre[2:0] == DCC_DIV8_LAST[2:0]);
      DCC_FCK_DIV32: t = (pre == DCC_DIV32_LAST);
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // readable image of a register at a byte address
  function automatic logic [7:0] reg_read(input dcc_state_t s, input logic [21:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      DCC_ADDR_FILTER_EDGE: v = s.filter_edge;
      DCC_ADDR_OUTPUT_CTRL: v = s.output_ctrl;
      DCC_ADDR_REF_GEN_CTRL: v = s.ref_gen_ctrl;
      DCC_ADDR_REF_LEVEL_CH0: v = s.ref_level0;
      DCC_ADDR_REF_LEVEL_CH1: v = s.ref_level1;
      DCC_ADDR_INPUT_SEL_CH0: v = s.input_sel0;
      DCC_ADDR_COMP_ENABLE: v = s.comp_enable;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [3:0] nib;
    logic [7:0] wb;
    logic [1:0] sample_now;
    logic [1:0] result;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] edge_hit;
    logic [1:0] ie_now;
    logic [1:0] shaped;
    logic [2:0] hist;
    logic win_ok;
    nib = 4'h0;
    wb = HWDATA[7:0];
    sample_now = 2'b00;
    result = 2'b00;
    rise = 2'b00;
    fall = 2'b00;
    edge_hit = 2'b00;
    ie_now = 2'b00;
    shaped = 2'b00;
    hist = 3'b000;
    win_ok = 1'b0;
    s_d = s_q;

    // bus: address phase capture, zero wait state data phase
    s_d.wr_pend = 1'b0;
    s_d.bus_st = DCC_BUS_IDLE;
    if (s_q.wr_pend) begin
      case (s_q.addr)
        DCC_ADDR_FILTER_EDGE: s_d.filter_edge = wb;
        DCC_ADDR_OUTPUT_CTRL: s_d.output_ctrl = wb & DCC_MASK_OUTPUT_CTRL;
        DCC_ADDR_REF_GEN_CTRL: s_d.ref_gen_ctrl = wb & DCC_MASK_REF_GEN_CTRL;
        DCC_ADDR_REF_LEVEL_CH0: s_d.ref_level0 = wb; // see (RQ16)
        DCC_ADDR_REF_LEVEL_CH1: s_d.ref_level1 = wb; // see (RQ16)
        DCC_ADDR_INPUT_SEL_CH0: s_d.input_sel0 = wb & DCC_MASK_INPUT_SEL_CH0;
        DCC_ADDR_COMP_ENABLE: s_d.comp_enable = wb & DCC_MASK_COMP_ENABLE;
        default: s_d.rdata = s_q.rdata;
      endcase
    end
    if (HSEL && HREADY && HTRANS[1]) begin
      s_d.bus_st = DCC_BUS_DATA;
      s_d.addr = HADDR[21:0];
      s_d.wr_pend = HWRITE;
      // unmapped or upper address bits read as zero
      s_d.rdata = (HADDR[31:22] == 10'h000) ? {24'h0, reg_read(s_q, HADDR[21:0])} : 32'h0;
    end

    // pin synchronisers; first stage feeds only the second
    s_d.raw_s1 = COMPARE_RAW;
    s_d.raw_s2 = s_q.raw_s1;
    s_d.win_s1 = TIMER_WINDOW_SIGNAL;
    s_d.win_s2 = s_q.win_s1;

    // shared free-running prescaler for /8 and /32 sampling
    s_d.prescale = s_q.prescale + 5'h01;

    // per channel filter, edge detection and irq request
    for (int c = 0; c < 2; c++) begin
      nib = s_q.filter_edge[c*DCC_CH_NIBBLE +: DCC_CH_NIBBLE];
      ie_now[c] = s_q.output_ctrl[c*DCC_CH_NIBBLE + DCC_OC_IE];
      sample_now[c] = samp_tick(nib[DCC_FE_FCK_LSB +: 2], s_q.prescale); // see (RQ3)
      if (dcc_fck_t'(nib[DCC_FE_FCK_LSB +: 2]) == DCC_FCK_BYPASS) begin
        result[c] = s_q.raw_s2[c]; // see (RQ3)
        s_d.samples[c*3 +: 3] = {3{s_q.raw_s2[c]}};
      end else begin
        result[c] = s_q.filt_out[c];
        if (sample_now[c]) begin
          hist = s_q.samples[c*3 +: 3];
          // three matching samples become the output at the next sample
          if (hist == 3'b111) begin
            result[c] = 1'b1; // see (RQ23)
          end else if (hist == 3'b000) begin
            result[c] = 1'b0; // see (RQ23)
          end
          s_d.samples[c*3 +: 3] = {hist[1:0], s_q.raw_s2[c]}; // see (RQ23)
        end
      end
      s_d.filt_out[c] = result[c];
      s_d.filt_prev[c] = result[c];
      rise[c] = result[c] & ~s_q.filt_prev[c];
      fall[c] = ~result[c] & s_q.filt_prev[c];
      if (nib[DCC_FE_EDG]) begin
        edge_hit[c] = rise[c] | fall[c]; // see (RQ1)
      end else begin
        edge_hit[c] = nib[DCC_FE_EPO] ? fall[c] : rise[c]; // see (RQ2)
      end
      // enabling irq can itself raise one request, as software is warned
      s_d.ie_prev[c] = ie_now[c];
      s_d.irq[c] = ie_now[c] & (edge_hit[c] | ~s_q.ie_prev[c]); // see (RQ12)
      // output polarity applied to the filtered result
      shaped[c] = result[c] ^ s_q.output_ctrl[c*DCC_CH_NIBBLE + DCC_OC_OP]; // see (RQ10)
    end

    // channel 1 window mode gates irq and pin by the timer window
    win_ok = ~s_q.output_ctrl[DCC_OC_TWMD] | s_q.win_s2;
    s_d.irq[1] = s_d.irq[1] & win_ok; // see (RQ24)
    s_d.pin0 = shaped[0] & s_q.output_ctrl[DCC_OC_OE]; // see (RQ11)
    s_d.pin1 = shaped[1] & s_q.output_ctrl[DCC_CH_NIBBLE + DCC_OC_OE] & win_ok; // see (RQ8)
    s_d.pwm_cut = shaped[0] & s_q.output_ctrl[DCC_OC_OE]; // see (RQ21)
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0; // see (RQ7)
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = 1'b1; // never waits: every access is zero wait state
  assign HRESP = 1'b0;
  assign IRQ_REQUEST = s_q.irq;
  assign COMPARE_OUT_PIN0 = s_q.pin0;
  assign COMPARE_OUT_PIN1 = s_q.pin1;
  assign PWM_CUTOFF_SOURCE = s_q.pwm_cut;
  assign COMPARATOR_ENABLE = {s_q.comp_enable[DCC_CH_NIBBLE], s_q.comp_enable[0]};
  // reference generator drive straight from register bits
  assign REF_GENERATOR_ENABLE = {s_q.ref_gen_ctrl[DCC_CH_NIBBLE + DCC_RG_EN],
                                 s_q.ref_gen_ctrl[DCC_RG_EN]}; // see (RQ14)
  assign REF_RAIL_SELECT = {s_q.ref_gen_ctrl[DCC_CH_NIBBLE + DCC_RG_RAIL],
                            s_q.ref_gen_ctrl[DCC_RG_RAIL]}; // see (RQ14)
  assign REF_LEVEL_CODE0 = s_q.ref_level0;
  assign REF_LEVEL_CODE1 = s_q.ref_level1;
  assign PLUS_INPUT_SELECT = s_q.input_sel0[DCC_IS_PLUS]; // see (RQ26)
  // code 11 is passed unchanged; the analog mux treats it as prohibited
  assign MINUS_INPUT_SELECT = s_q.input_sel0[DCC_IS_MINUS_LSB +: 2]; // see (RQ25)

endmodule // dcc_top

/* dcc_chk.sv */
// checker: port-level assertions for the comparator control block
module dcc_chk
  import dcc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic [1:0] COMPARE_RAW,
  input wire logic TIMER_WINDOW_SIGNAL,
  input wire logic [1:0] IRQ_REQUEST,
  input wire logic COMPARE_OUT_PIN0,
  input wire logic COMPARE_OUT_PIN1,
  input wire logic PWM_CUTOFF_SOURCE,
  input wire logic [7:0] REF_LEVEL_CODE0
);
  // ****************
  // register mirror
  // ****************
  logic ph_q;
  logic [21:0] a_q;
  logic [7:0] oc_q, fe_q;
  // mirror of bus writes; one slave and zero wait, so ready is not decoded
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ph_q <= 1'b0;
      a_q <= '0;
      oc_q <= 8'h00;
      fe_q <= 8'h00;
    end else begin
      ph_q <= HTRANS[1] && HWRITE;
      a_q <= HADDR[21:0];
      if (ph_q && a_q == DCC_ADDR_OUTPUT_CTRL) oc_q <= HWDATA[7:0] & DCC_MASK_OUTPUT_CTRL;
      if (ph_q && a_q == DCC_ADDR_FILTER_EDGE) fe_q <= HWDATA[7:0];
    end
  end
  // ch0 interrupt on, bypass filter, single rising or both edges
  wire logic rise0 = oc_q[DCC_OC_IE] && fe_q[3:0] == 4'h0;
  wire logic both0 = oc_q[DCC_OC_IE] && fe_q[3:0] == 4'h8;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  chk_pin_gate: assert property ((!oc_q[DCC_OC_OE])[*4] |-> !COMPARE_OUT_PIN0)
    else $error("pin0 driven while disabled");
  chk_pwm_pin: assert property (PWM_CUTOFF_SOURCE == COMPARE_OUT_PIN0)
    else $error("cutoff source differs from pin0");
  // raw seen one edge after it changes: two sync stages and the irq flop follow
  chk_rise_only: assert property (rise0 && $rose(COMPARE_RAW[0]) |-> ##3 IRQ_REQUEST[0])
    else $error("no request on rising edge");
  chk_fall_quiet: assert property (rise0 && $fell(COMPARE_RAW[0]) |-> ##3 !IRQ_REQUEST[0])
    else $error("request on falling edge in rising mode");
  chk_both_fall: assert property (both0 && $fell(COMPARE_RAW[0]) |-> ##3 IRQ_REQUEST[0])
    else $error("no request on falling edge in both mode");
  chk_win_hold: assert property (
    (oc_q[DCC_OC_TWMD] && !TIMER_WINDOW_SIGNAL)[*5] |-> !IRQ_REQUEST[1] && !COMPARE_OUT_PIN1)
    else $error("ch1 active while window closed");
  chk_pin_pol: assert property (
    (oc_q[DCC_OC_OE] && fe_q[1:0] == 2'b00 && $stable(oc_q) && $stable(COMPARE_RAW[0]))[*6]
    |-> COMPARE_OUT_PIN0 == (COMPARE_RAW[0] ^ oc_q[DCC_OC_OP]))
    else $error("pin0 polarity wrong");
  chk_ref_code: assert property (
    ph_q && a_q == DCC_ADDR_REF_LEVEL_CH0 |=> REF_LEVEL_CODE0 == $past(HWDATA[7:0]))
    else $error("reference code not taken from write");
endmodule // dcc_chk

bind dcc_top dcc_chk u_dcc_chk (.CLK_SYS, .RST_B, .HADDR, .HTRANS, .HWRITE, .HWDATA, .COMPARE_RAW,
  .TIMER_WINDOW_SIGNAL, .IRQ_REQUEST, .COMPARE_OUT_PIN0, .COMPARE_OUT_PIN1, .PWM_CUTOFF_SOURCE,
  .REF_LEVEL_CODE0);

/* dcc_irq_sink.sv */
// partner: interrupt controller model counting pending requests per channel
module dcc_irq_sink (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] irq,
  input wire logic clr,
  output logic [7:0] cnt0,
  output logic [7:0] cnt1
);
  // ********
  // pending
  // ********
  // software clears the flags after reconfiguring a channel
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt0, cnt1} <= 16'h0000;
    end else if (clr) begin
      // a request in the clearing cycle still counts: the set wins
      {cnt0, cnt1} <= {8'(irq[0]), 8'(irq[1])};
    end else begin
      cnt0 <= cnt0 + 8'(irq[0]);
      cnt1 <= cnt1 + 8'(irq[1]);
    end
  end
endmodule // dcc_irq_sink

/* dcc_top_tb.sv */
// testbench: bus-driven scenarios for the comparator control block
module dcc_top_tb
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // harness
  // ********
  logic CLK_SYS = 1'b0, RST_B = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, TIMER_WINDOW_SIGNAL = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic [1:0] HTRANS = 2'b00, COMPARE_RAW = 2'b00, IRQ_REQUEST, COMPARATOR_ENABLE;
  logic HREADYOUT, HRESP, COMPARE_OUT_PIN0, COMPARE_OUT_PIN1, PWM_CUTOFF_SOURCE, PLUS_INPUT_SELECT;
  logic [1:0] REF_GENERATOR_ENABLE, REF_RAIL_SELECT, MINUS_INPUT_SELECT;
  logic [7:0] REF_LEVEL_CODE0, REF_LEVEL_CODE1, cnt0, cnt1;
  logic clr = 1'b0;
  wire logic HREADY = HREADYOUT;
  int n_errors = 0, check_count = 0, dv;
  logic [21:0] regs[7] = '{DCC_ADDR_FILTER_EDGE, DCC_ADDR_OUTPUT_CTRL, DCC_ADDR_REF_GEN_CTRL,
    DCC_ADDR_REF_LEVEL_CH0, DCC_ADDR_REF_LEVEL_CH1, DCC_ADDR_INPUT_SEL_CH0, 22'h000100};
  // single slave: its own ready is the bus ready
  dcc_top u_dcc_top (.CLK_SYS, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'b010), .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .COMPARE_RAW, .TIMER_WINDOW_SIGNAL, .IRQ_REQUEST,
    .COMPARE_OUT_PIN0, .COMPARE_OUT_PIN1, .PWM_CUTOFF_SOURCE, .COMPARATOR_ENABLE,
    .REF_GENERATOR_ENABLE, .REF_RAIL_SELECT, .REF_LEVEL_CODE0, .REF_LEVEL_CODE1,
    .PLUS_INPUT_SELECT, .MINUS_INPUT_SELECT);
  dcc_irq_sink u_dcc_irq_sink (.clk(CLK_SYS), .rst_b(RST_B), .irq(IRQ_REQUEST), .clr, .cnt0, .cnt1);
  // 100 MHz clock
  initial begin
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  // bounded wait: a slave that never answers ends the run
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge CLK_SYS);
      if (HREADYOUT === 1'b1) break;
    end
    if (i == 40) begin
      n_errors++;
      wrap_up();
    end
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [21:0] a, input logic [7:0] d, output logic [31:0] r);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {10'h000, a};
    HWRITE <= w;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= {24'h000000, d};
    wait_rdy();
    r = HRDATA;
  endtask
  // the extra cycle lets the register's outputs settle before a look
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    cyc(1);
  endtask
  task automatic rd(input string what, input logic [21:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    check(what, r, {24'h000000, e});
  endtask
  task automatic clear;
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
  endtask
  // main sequence
  initial begin
    cyc(16);
    RST_B <= 1'b1;
    cyc(1);
    foreach (regs[i]) rd("reset", regs[i], 8'h00);
    check("hresp", 32'({HREADYOUT, HRESP}), 32'h2);
    wr(DCC_ADDR_REF_LEVEL_CH0, 8'ha5); // generator still stopped
    wr(DCC_ADDR_REF_LEVEL_CH1, 8'h5a); // whole byte write
    check("code1", 32'(REF_LEVEL_CODE1), 32'h5a);
    rd("level0", DCC_ADDR_REF_LEVEL_CH0, 8'ha5);
    check("code0", 32'(REF_LEVEL_CODE0), 32'ha5);
    // no shared reference pin serves as a ch1 input here
    wr(DCC_ADDR_REF_GEN_CTRL, 8'h11); // rails set while stopped
    wr(DCC_ADDR_REF_GEN_CTRL, 8'hff);
    rd("refgen", DCC_ADDR_REF_GEN_CTRL, 8'h33);
    check("gen", 32'({REF_GENERATOR_ENABLE, REF_RAIL_SELECT}), 32'hf);
    wr(DCC_ADDR_INPUT_SEL_CH0, 8'h82); // comparator 0 still off
    check("insel", 32'({PLUS_INPUT_SELECT, MINUS_INPUT_SELECT}), 32'h6);
    // speed mode is never rewritten while the comparators run
    wr(DCC_ADDR_COMP_ENABLE, 8'h11); // before any pin enable
    check("cmp_en", 32'(COMPARATOR_ENABLE), 32'h3);
    wr(DCC_ADDR_OUTPUT_CTRL, 8'h01);
    cyc(8);
    check("ie_post", 32'(cnt0), 32'h1);
    // rising only, falling only, both edges
    for (int m = 0; m < 3; m++) begin
      wr(DCC_ADDR_FILTER_EDGE, 8'(m * 4));
      cyc(8);
      clear();
      COMPARE_RAW[0] <= 1'b1;
      cyc(10);
      check("rise", 32'(cnt0), 32'(m != 1));
      COMPARE_RAW[0] <= 1'b0;
      cyc(10);
      check("fall", 32'(cnt0), 32'(m != 1) + 32'(m != 0));
    end
    for (int p = 0; p < 4; p++) begin
      wr(DCC_ADDR_OUTPUT_CTRL, {5'b00000, p[1], 2'b11});
      COMPARE_RAW[0] <= p[0];
      cyc(10);
      check("pin0", 32'(COMPARE_OUT_PIN0), 32'(p[0] ^ p[1]));
      check("pwm", 32'(PWM_CUTOFF_SOURCE), 32'(p[0] ^ p[1]));
    end
    COMPARE_RAW[0] <= 1'b0;
    wr(DCC_ADDR_OUTPUT_CTRL, 8'h05);
    cyc(10);
    check("pin0_off", 32'(COMPARE_OUT_PIN0), 32'h0);
    clear();
    // filter codes with their sampling dividers
    for (int k = 1; k < 4; k++) begin
      dv = (k == 1) ? 1 : (k == 2) ? DCC_DIV_8 : DCC_DIV_32;
      wr(DCC_ADDR_FILTER_EDGE, 8'(8 + k));
      cyc(4 * dv + 4);
      clear();
      COMPARE_RAW[0] <= ~COMPARE_RAW[0];
      cyc(2 * dv);
      check("flt_early", 32'(cnt0), 32'h0);
      cyc(4 * dv + 10);
      check("flt", 32'(cnt0), 32'h1);
    end
    wr(DCC_ADDR_FILTER_EDGE, 8'h00);
    wr(DCC_ADDR_OUTPUT_CTRL, 8'h90);
    wr(DCC_ADDR_OUTPUT_CTRL, 8'hb0);
    cyc(8);
    clear();
    COMPARE_RAW[1] <= 1'b1;
    cyc(10);
    check("win_pin", 32'(COMPARE_OUT_PIN1), 32'h0);
    check("win_irq", 32'(cnt1), 32'h0);
    TIMER_WINDOW_SIGNAL <= 1'b1;
    COMPARE_RAW[1] <= 1'b0;
    cyc(10);
    COMPARE_RAW[1] <= 1'b1;
    cyc(10);
    check("open_pin", 32'(COMPARE_OUT_PIN1), 32'h1);
    check("open_irq", 32'(cnt1), 32'h1);
    wrap_up();
  end
endmodule // dcc_top_tb
